// [include/mrd_pkg.sv]
// Behaviour
// RQ1 - coils are one-bit, readable and writable
// RQ2 - discrete inputs are one-bit, read only
// RQ3 - input registers are 16-bit, read only
// RQ4 - holding registers are 16-bit, read/write
// RQ5 - four overlapping spaces chosen by function code
// RQ6 - reads: 1 coil, 2 disc, 3 hold, 4 input
// RQ7 - writes: 5 coil, 6 hold, 15 coils, 16 holds
// RQ8 - erroneous request gets exception instead of data
// RQ9 - exception: unit, function with msb set, code
// RQ10 - code 1 for unknown or disallowed function
// RQ11 - code 2 when any addressed register missing
// RQ12 - code 3 for unacceptable data value
// RQ13 - code 4 on failure, 6 while busy
// RQ14 - master retries later after busy
// RQ15 - gateway codes 0A path, 0B no response
// RQ16 - code 11 hex for downstream timeout
// RQ17 - addresses 0 to 65535 in each space
// RQ18 - five-digit leading digit selects space
// RQ19 - address is reference minus base plus one; the code takes reference minus base minus one (40001 gives 0)
// RQ20 - six-digit extended ranges also recognised
// RQ21 - at most one reply per request
package mrd_pkg;

  // function codes
  localparam logic [7:0] MRD_FC_RD_COIL = 8'h01;
  localparam logic [7:0] MRD_FC_RD_DISC = 8'h02;
  localparam logic [7:0] MRD_FC_RD_HOLD = 8'h03;
  localparam logic [7:0] MRD_FC_RD_INP = 8'h04;
  localparam logic [7:0] MRD_FC_WR_COIL = 8'h05;
  localparam logic [7:0] MRD_FC_WR_HOLD = 8'h06;
  localparam logic [7:0] MRD_FC_WR_COILS = 8'h0F;
  localparam logic [7:0] MRD_FC_WR_HOLDS = 8'h10;
  localparam logic [7:0] MRD_FC_EXC_BIT = 8'h80;

  // exception codes
  localparam logic [7:0] MRD_EX_NONE = 8'h00;
  localparam logic [7:0] MRD_EX_FUNC = 8'h01;
  localparam logic [7:0] MRD_EX_ADDR = 8'h02;
  localparam logic [7:0] MRD_EX_VALUE = 8'h03;
  localparam logic [7:0] MRD_EX_FAIL = 8'h04;
  localparam logic [7:0] MRD_EX_BUSY = 8'h06;
  localparam logic [7:0] MRD_EX_PATH = 8'h0A;
  localparam logic [7:0] MRD_EX_NORESP = 8'h0B;
  localparam logic [7:0] MRD_EX_TIMEOUT = 8'h11;

  // coil write values for single coil write
  localparam logic [15:0] MRD_COIL_ON = 16'hFF00;
  localparam logic [15:0] MRD_COIL_OFF = 16'h0000;
  // count limits for multi reads/writes
  localparam logic [15:0] MRD_MAX_BITS_RD = 16'h07D0;
  localparam logic [15:0] MRD_MAX_REGS_RD = 16'h007D;
  localparam logic [15:0] MRD_MAX_BITS_WR = 16'h07B0;
  localparam logic [15:0] MRD_MAX_REGS_WR = 16'h007B;

  // legacy reference bases
  localparam logic [19:0] MRD_REF5_SPAN = 20'h02710; // 10000
  localparam logic [19:0] MRD_REF5_MAX = 20'h0270F; // 9999
  localparam logic [19:0] MRD_REF6_SPAN = 20'h186A0; // 100000
  localparam logic [19:0] MRD_REF6_MAX = 20'h0FFFF; // 65535
  localparam logic [2:0] MRD_DIG_COIL = 3'h0;
  localparam logic [2:0] MRD_DIG_DISC = 3'h1;
  localparam logic [2:0] MRD_DIG_INP = 3'h3;
  localparam logic [2:0] MRD_DIG_HOLD = 3'h4;

  // register spaces
  typedef enum logic [3:0] {
    MRD_SP_COIL = 4'b0001,
    MRD_SP_DISC = 4'b0010,
    MRD_SP_INP = 4'b0100,
    MRD_SP_HOLD = 4'b1000
  } mrd_space_e;

  // decoder states
  typedef enum logic [2:0] {
    MRD_ST_IDLE = 3'b001,
    MRD_ST_CHECK = 3'b010,
    MRD_ST_REPLY = 3'b100
  } mrd_state_e;

  // request from framing logic
  typedef struct packed {
    logic [7:0] unit;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] value;
  } mrd_req_s;

  // reply toward framing logic
  typedef struct packed {
    logic [7:0] unit;
    logic [7:0] func;
    logic exc;
    logic [7:0] code;
    logic wr;
    mrd_space_e space;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] value;
  } mrd_rsp_s;

  // status inputs from the rest of the gateway
  typedef struct packed {
    logic fail;
    logic busy;
    logic path_down;
    logic no_resp;
    logic timeout;
  } mrd_stat_s;

endpackage

// [rtl/mrd_space_check.sv]
// checks a range against the size of one space and its width
module mrd_space_check
  import mrd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] count_i,
  input wire logic [ADDR_W:0] size_i,
  output logic ok_o
);
  // refuse address widths the 17-bit range sum cannot serve
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("mrd_space_check: ADDR_W out of range");
  end

  logic [16:0] last;

  // one past the last address of the range; the whole range must exist
  always_comb begin
    last = {1'b0, 16'(addr_i)} + {1'b0, count_i};
    ok_o = (count_i != 16'h0000) && (17'(size_i) >= last); // RQ11 RQ17
  end
endmodule

// [rtl/mrd_ref_convert.sv]
// legacy five/six digit reference to space plus address
module mrd_ref_convert
  import mrd_pkg::*;
(
  input wire logic [19:0] ref_i,
  input wire logic six_i,
  output logic valid_o,
  output mrd_space_e space_o,
  output logic [15:0] addr_o
);
  logic [2:0] digit;
  logic [19:0] rest;
  logic [19:0] span;
  logic [19:0] lim;

  // leading digit by repeated span subtraction
  always_comb begin
    span = six_i ? MRD_REF6_SPAN : MRD_REF5_SPAN; // RQ18 RQ20
    lim = six_i ? MRD_REF6_MAX : MRD_REF5_MAX;
    digit = 3'h0;
    rest = ref_i;
    for (int i = 0; i < 5; i++) begin
      if (rest >= span) begin
        rest = rest - span;
        digit = digit + 3'h1;
      end
    end
    valid_o = (rest != 20'h00000) && ((rest - 20'h00001) <= lim) &&
              (ref_i < 20'(span * 20'h00005));
    addr_o = 16'(rest - 20'h00001); // RQ19
    space_o = MRD_SP_COIL;
    case (digit)
      MRD_DIG_COIL: space_o = MRD_SP_COIL;
      MRD_DIG_DISC: space_o = MRD_SP_DISC;
      MRD_DIG_INP: space_o = MRD_SP_INP;
      MRD_DIG_HOLD: space_o = MRD_SP_HOLD;
      default: valid_o = 1'b0;
    endcase
  end
endmodule

// [rtl/mrd_decoder.sv]
// request decoder: function code and address checks, exception replies
module mrd_decoder
  import mrd_pkg::*;
#(
  parameter int COIL_N = 65536,
  parameter int DISC_N = 65536,
  parameter int INP_N = 65536,
  parameter int HOLD_N = 65536
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire mrd_req_s req_i,
  input wire mrd_stat_s stat_i,
  input wire logic gw_mode_i,
  input wire logic [19:0] ref_i,
  input wire logic ref_six_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output mrd_rsp_s rsp_o,
  output logic ref_valid_o,
  output mrd_space_e ref_space_o,
  output logic [15:0] ref_addr_o
);
  // refuse space sizes the 16-bit address cannot reach
  if (COIL_N < 1 || COIL_N > 65536 || DISC_N < 1 || DISC_N > 65536 ||
      INP_N < 1 || INP_N > 65536 || HOLD_N < 1 || HOLD_N > 65536) begin : g_bad_size
    $error("mrd_decoder: space size out of range");
  end

  localparam logic [16:0] COIL_SZ = 17'(COIL_N);
  localparam logic [16:0] DISC_SZ = 17'(DISC_N);
  localparam logic [16:0] INP_SZ = 17'(INP_N);
  localparam logic [16:0] HOLD_SZ = 17'(HOLD_N);

  typedef struct packed {
    mrd_state_e st;
    mrd_req_s req;
    logic ready;
    logic rvalid;
    mrd_rsp_s rsp;
    logic refv;
    mrd_space_e refsp;
    logic [15:0] refad;
  } mrd_state_s;

  mrd_state_s s_reg;
  mrd_state_s s_next;

  // decode of the held request
  logic known;
  logic is_wr;
  logic multi;
  mrd_space_e space;
  logic [16:0] size;
  logic range_ok;
  logic value_ok;
  logic [15:0] eff_cnt;
  logic [15:0] max_cnt;
  logic cv_valid;
  mrd_space_e cv_space;
  logic [15:0] cv_addr;

  // function code picks space and direction
  always_comb begin
    known = 1'b1;
    is_wr = 1'b0;
    multi = 1'b1;
    space = MRD_SP_HOLD;
    max_cnt = MRD_MAX_REGS_RD;
    case (s_reg.req.func) // RQ5 RQ6 RQ7
      MRD_FC_RD_COIL: begin
        space = MRD_SP_COIL; // RQ1
        max_cnt = MRD_MAX_BITS_RD;
      end
      MRD_FC_RD_DISC: begin
        space = MRD_SP_DISC; // RQ2
        max_cnt = MRD_MAX_BITS_RD;
      end
      MRD_FC_RD_HOLD: space = MRD_SP_HOLD; // RQ4
      MRD_FC_RD_INP: space = MRD_SP_INP; // RQ3
      MRD_FC_WR_COIL: begin
        space = MRD_SP_COIL;
        is_wr = 1'b1;
        multi = 1'b0;
      end
      MRD_FC_WR_HOLD: begin
        space = MRD_SP_HOLD;
        is_wr = 1'b1;
        multi = 1'b0;
      end
      MRD_FC_WR_COILS: begin
        space = MRD_SP_COIL;
        is_wr = 1'b1;
        max_cnt = MRD_MAX_BITS_WR;
      end
      MRD_FC_WR_HOLDS: begin
        space = MRD_SP_HOLD;
        is_wr = 1'b1;
        max_cnt = MRD_MAX_REGS_WR;
      end
      default: known = 1'b0; // RQ10: writes to inputs land here too
    endcase
  end

  // size of the addressed space
  always_comb begin
    size = HOLD_SZ;
    case (space)
      MRD_SP_COIL: size = COIL_SZ;
      MRD_SP_DISC: size = DISC_SZ;
      MRD_SP_INP: size = INP_SZ;
      MRD_SP_HOLD: size = HOLD_SZ;
      default: size = HOLD_SZ;
    endcase
  end

  // single writes touch one location
  always_comb begin
    eff_cnt = multi ? s_reg.req.count : 16'h0001;
    value_ok = 1'b1;
    if (multi) begin
      value_ok = (s_reg.req.count != 16'h0000) &&
                 (s_reg.req.count <= max_cnt); // RQ12
    end else if (space == MRD_SP_COIL) begin
      value_ok = (s_reg.req.value == MRD_COIL_ON) ||
                 (s_reg.req.value == MRD_COIL_OFF); // RQ12
    end
  end

  mrd_space_check #(
    .ADDR_W(16)
  ) u_check (
    .addr_i(s_reg.req.addr),
    .count_i(eff_cnt),
    .size_i(size),
    .ok_o(range_ok)
  );

  mrd_ref_convert u_ref (
    .ref_i(ref_i),
    .six_i(ref_six_i),
    .valid_o(cv_valid),
    .space_o(cv_space),
    .addr_o(cv_addr)
  );

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.refv = cv_valid; // RQ18 RQ20
    s_next.refsp = cv_space;
    s_next.refad = cv_addr; // RQ19
    case (s_reg.st)
      MRD_ST_IDLE: begin
        s_next.ready = 1'b1;
        if (req_valid_i && s_reg.ready) begin
          s_next.req = req_i;
          s_next.ready = 1'b0;
          s_next.st = MRD_ST_CHECK;
        end
      end
      MRD_ST_CHECK: begin
        s_next.rsp.unit = s_reg.req.unit; // RQ9
        s_next.rsp.wr = is_wr;
        s_next.rsp.space = space;
        s_next.rsp.addr = s_reg.req.addr; // RQ17
        s_next.rsp.count = eff_cnt;
        s_next.rsp.value = s_reg.req.value;
        s_next.rsp.exc = 1'b1; // RQ8
        s_next.rsp.func = s_reg.req.func | MRD_FC_EXC_BIT; // RQ9
        // priority: internal state first, then request checks
        if (stat_i.fail) begin
          s_next.rsp.code = MRD_EX_FAIL; // RQ13
        end else if (stat_i.busy) begin
          s_next.rsp.code = MRD_EX_BUSY; // RQ13 RQ14
        end else if (!known) begin
          s_next.rsp.code = MRD_EX_FUNC; // RQ10
        end else if (!value_ok) begin
          s_next.rsp.code = MRD_EX_VALUE; // RQ12
        end else if (!range_ok) begin
          s_next.rsp.code = MRD_EX_ADDR; // RQ11
        end else if (gw_mode_i && stat_i.path_down) begin
          s_next.rsp.code = MRD_EX_PATH; // RQ15
        end else if (gw_mode_i && stat_i.no_resp) begin
          s_next.rsp.code = MRD_EX_NORESP; // RQ15
        end else if (gw_mode_i && stat_i.timeout) begin
          s_next.rsp.code = MRD_EX_TIMEOUT; // RQ16
        end else begin
          s_next.rsp.exc = 1'b0;
          s_next.rsp.func = s_reg.req.func;
          s_next.rsp.code = MRD_EX_NONE;
        end
        s_next.rvalid = 1'b1; // RQ21: single pulse per request
        s_next.st = MRD_ST_REPLY;
      end
      MRD_ST_REPLY: begin
        s_next.ready = 1'b1;
        s_next.st = MRD_ST_IDLE;
      end
      default: begin
        s_next.st = MRD_ST_IDLE;
        s_next.ready = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.st <= MRD_ST_IDLE;
      s_reg.rsp.space <= MRD_SP_COIL;
      s_reg.refsp <= MRD_SP_COIL;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign req_ready_o = s_reg.ready;
  assign rsp_valid_o = s_reg.rvalid;
  assign rsp_o = s_reg.rsp;
  assign ref_valid_o = s_reg.refv;
  assign ref_space_o = s_reg.refsp;
  assign ref_addr_o = s_reg.refad;
endmodule

// [bench/mrd_decoder_sva.sv]
// timing and reply-format checks on the decoder ports
module mrd_decoder_chk
  import mrd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire mrd_req_s req_i,
  input wire mrd_stat_s stat_i,
  input wire logic [19:0] ref_i,
  input wire logic ref_six_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire mrd_rsp_s rsp_o,
  input wire logic ref_valid_o,
  input wire mrd_space_e ref_space_o,
  input wire logic [15:0] ref_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // request accepted at this edge
  wire take = req_valid_i && req_ready_o;
  property p_lat;
    take |=> !rsp_valid_o ##1 rsp_valid_o ##1 !rsp_valid_o;
  endproperty
  a_lat: assert property (p_lat) else $error("bad reply timing");
  property p_rdy;
    take |=> !req_ready_o [*2] ##1 req_ready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("bad ready timing");
  property p_unit;
    take |-> ##2 rsp_o.unit == $past(req_i.unit, 2);
  endproperty
  a_unit: assert property (p_unit) else $error("bad reply unit");
  property p_func;
    take |-> ##2 rsp_o.func == ($past(req_i.func, 2) | {rsp_o.exc, 7'h00});
  endproperty
  a_func: assert property (p_func) else $error("bad reply func");
  property p_code;
    rsp_valid_o |-> rsp_o.exc == (rsp_o.code != MRD_EX_NONE);
  endproperty
  a_code: assert property (p_code) else $error("exc flag vs code");
  property p_fail;
    take ##1 stat_i.fail |=> rsp_o.code == MRD_EX_FAIL;
  endproperty
  a_fail: assert property (p_fail) else $error("no failure code");
  property p_busy;
    take ##1 (stat_i.busy && !stat_i.fail) |=> rsp_o.code == MRD_EX_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("no busy code");
  property p_hold;
    take && req_i.func == MRD_FC_WR_HOLD ##1 stat_i == '0
      |=> !rsp_o.exc && rsp_o.wr && rsp_o.space == MRD_SP_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("bad hold write");
  property p_ref;
    !ref_six_i && ref_i == 20'h09C41 |=> ref_valid_o &&
      ref_space_o == MRD_SP_HOLD && ref_addr_o == 16'h0000;
  endproperty
  a_ref: assert property (p_ref) else $error("bad ref convert");
  c_exc: cover property (rsp_valid_o && rsp_o.exc);
  c_ok: cover property (rsp_valid_o && !rsp_o.exc);
  c_ref: cover property (ref_valid_o);
endmodule

bind mrd_decoder mrd_decoder_chk i_chk (.ref_clk_i, .rst_n_i, .req_valid_i,
  .req_i, .stat_i, .ref_i, .ref_six_i, .req_ready_o, .rsp_valid_o, .rsp_o,
  .ref_valid_o, .ref_space_o, .ref_addr_o);

// [bench/mrd_master.sv]
// master side: one request at a time, held until taken
module mrd_master
  import mrd_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic rsp_valid_i,
  input wire mrd_rsp_s rsp_i,
  output logic valid_o,
  output mrd_req_s req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at start
  initial begin
    valid_o = 1'b0;
    req_o = '0;
  end
  // ready is a flop, so its value just after an edge is what the next
  // edge samples; the reply pulse stands after the edge following the take
  task automatic xfer(input mrd_req_s r, output mrd_rsp_s q,
                      output logic got);
    int n;
    n = 0;
    @(posedge clk_i);
    #1 valid_o = 1'b1;
    req_o = r;
    while (ready_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    #1 valid_o = 1'b0;
    req_o = ~r; // released lines carry no stale value
    @(posedge clk_i);
    #1 q = rsp_i;
    got = rsp_valid_i;
  endtask
endmodule

// [bench/mrd_decoder_tb_top.sv]
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module mrd_decoder_tb_top
  import mrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gw_mode_i = 1'b0;
  logic ref_six_i = 1'b0;
  logic [19:0] ref_i = '0;
  mrd_stat_s stat_i = '0;
  logic req_valid_i, req_ready_o, rsp_valid_o, ref_valid_o, got;
  mrd_req_s req_i;
  mrd_rsp_s rsp_o, q;
  mrd_space_e ref_space_o;
  logic [15:0] ref_addr_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // free running clock
  always #2 ref_clk_i = ~ref_clk_i;
  mrd_decoder i_dut (.ref_clk_i, .rst_n_i, .req_valid_i, .req_i, .stat_i,
    .gw_mode_i, .ref_i, .ref_six_i, .req_ready_o, .rsp_valid_o, .rsp_o,
    .ref_valid_o, .ref_space_o, .ref_addr_o);
  mrd_master i_mst (.clk_i(ref_clk_i), .ready_i(req_ready_o),
    .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o), .valid_o(req_valid_i),
    .req_o(req_i));
  // send one request and check a reply came
  task automatic go(input logic [7:0] f, input logic [15:0] a, c, v);
    i_mst.xfer('{8'h11, f, a, c, v}, q, got);
    `CHK(got, 1'b1)
  endtask
  // check unit, echoed function and exception code
  task automatic ex(input logic [7:0] f, c);
    logic [24:0] e;
    e = {8'h11, f | {c != 8'h00, 7'h00}, c != 8'h00, c};
    `CHK({q.unit, q.func, q.exc, q.code}, e)
  endtask
  // every read and write code reaches the right space
  task automatic t_access;
    logic [7:0] f[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F,
      8'h10};
    logic [3:0] s[8] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h1, 4'h8, 4'h1, 4'h8};
    logic [31:0] cv;
    for (int i = 0; i < 8; i++) begin
      go(f[i], 16'hFFF8, 16'h0008, MRD_COIL_ON);
      ex(f[i], 8'h00);
      // single writes report one location; the value is echoed
      cv = {(i == 4 || i == 5) ? 16'h0001 : 16'h0008, MRD_COIL_ON};
      `CHK(q.space, s[i])
      `CHK({q.wr, q.addr}, {i > 3, 16'hFFF8})
      `CHK({q.count, q.value}, cv)
    end
  endtask
  // illegal function, address and value, plus the largest legal coil read count
  task automatic t_exc;
    logic [63:0] t[7] = '{64'h07_0000_0001_0000_01, 64'h0F_FFF9_0008_0000_02,
      64'h05_0000_0001_1234_03, 64'h03_0000_0000_0000_03,
      64'h01_0000_07D1_0000_03, 64'h01_0000_07D0_0000_00,
      64'h10_0000_007C_0000_03};
    for (int i = 0; i < 7; i++) begin
      go(t[i][63:56], t[i][55:40], t[i][39:24], t[i][23:8]);
      ex(t[i][63:56], t[i][7:0]);
    end
  endtask
  // status driven codes, busy last then a retry
  task automatic t_stat;
    logic [15:0] t[5] = '{16'h10_04, 16'h04_0A, 16'h02_0B, 16'h01_11,
      16'h08_06};
    gw_mode_i = 1'b1;
    for (int i = 0; i < 5; i++) begin
      stat_i = t[i][12:8];
      go(8'h03, 16'h0000, 16'h0001, 16'h0000);
      ex(8'h03, t[i][7:0]);
    end
    stat_i = '0;
    go(8'h03, 16'h0000, 16'h0001, 16'h0000);
    ex(8'h03, 8'h00);
  endtask
  // legacy reference conversion
  task automatic t_ref;
    logic [47:0] r[7] = '{48'h0_00001_1_1_0000, 48'h0_09C41_1_8_0000,
      48'h0_07531_1_4_0000, 48'h0_0C34F_1_8_270E, 48'h0_04E21_0_0_0000,
      48'h1_71A7F_1_8_FFFE, 48'h1_186A1_1_2_0000};
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk_i);
      #1 {ref_six_i, ref_i} = {r[i][44], r[i][43:24]};
      @(posedge ref_clk_i);
      #1 `CHK(ref_valid_o, r[i][20])
      if (r[i][20]) `CHK({ref_space_o, ref_addr_o}, r[i][19:0])
    end
  endtask
  // verdict and end of run
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    t_access;
    t_exc;
    t_stat;
    t_ref;
    results;
  end
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      results;
    end
  end
endmodule
